// ### design/uart_lin_break_baud_gen.sv
/*
  Serial receiver/transmitter with noise filter, break send/receive,
  error flags and a prescaler plus one 8-bit divider shared by transmit and receive.
  Assumes one 100 MHz clock clk_sys, an Avalon-MM master with
  waitrequest, and an asynchronous serial_in_pin.
*/
`timescale 1ns/100ps
module uart_lin_break_baud_gen #(
  parameter logic [39:0] BREAK_LEN_MAP = uart_lin_pkg::BRK_MAP_RST
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic rx_done_irq,
  output logic rx_error_irq,
  output logic tx_done_irq
);
  logic ack_q;
  logic [7:0] mode_q;
  logic [2:0] blen_sel_q;
  logic btx_trig_q, brx_trig_q, brx_flag_q;
  logic [2:0] err_q;
  logic [7:0] rx_buf_q, tx_buf_q, div_q;
  logic rx_full_q, tx_pend_q;
  logic [3:0] clk_sel_q;
  logic [10:0] presc_q;
  logic rx_meta_q, rx_sync_q, rx_samp_q, rx_filt_q, rx_prev_q;
  logic [7:0] rx_cnt_q, tx_cnt_q;
  logic rx_half_q, tx_half_q;
  uart_lin_pkg::rx_state_e rx_state_q;
  uart_lin_pkg::tx_state_e tx_state_q;
  logic [7:0] rx_shift_q, tx_shift_q;
  logic [2:0] rx_bitn_q, tx_bitn_q;
  logic rx_par_q, tx_par_q, tx_stop2_q;
  logic [4:0] rx_low_q, tx_brk_cnt_q;

  // Bus: one wait cycle, read data latched at the edge that ends the wait, effects at the next edge
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  wire wr_acc = avs_write & ack_q & avs_byteenable[0];
  wire rd_acc = avs_read & ack_q;
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_mode = wr_acc && avs_address == uart_lin_pkg::ADDR_MODE;
  wire wr_ctrl = wr_acc && avs_address == uart_lin_pkg::ADDR_CTRL;
  wire wr_txbuf = wr_acc && avs_address == uart_lin_pkg::ADDR_TXBUF;
  wire wr_clksel = wr_acc && avs_address == uart_lin_pkg::ADDR_CLKSEL;
  wire wr_div = wr_acc && avs_address == uart_lin_pkg::ADDR_DIV;
  wire rd_err = rd_acc && avs_address == uart_lin_pkg::ADDR_ERR;
  wire rd_rxbuf = rd_acc && avs_address == uart_lin_pkg::ADDR_RXBUF;

  wire power = mode_q[uart_lin_pkg::MODE_POWER];
  wire [1:0] par_mode = mode_q[uart_lin_pkg::MODE_PAR_LO +: 2];
  wire len8 = mode_q[uart_lin_pkg::MODE_LEN8];
  wire merge = mode_q[uart_lin_pkg::MODE_MERGE];
  wire tx_run = power & mode_q[uart_lin_pkg::MODE_TXE];
  wire rx_run = power & mode_q[uart_lin_pkg::MODE_RXE];
  wire [2:0] last_bit = len8 ? 3'h7 : 3'h6;

  wire [7:0] ctrl_rd = {brx_flag_q, brx_trig_q, btx_trig_q, blen_sel_q, 2'h0};
  wire [7:0] stat_rd = {5'h00, rx_full_q, tx_state_q != uart_lin_pkg::TX_IDLE, tx_pend_q};
  wire [7:0] rd_mux =
    avs_address == uart_lin_pkg::ADDR_MODE ? mode_q :
    avs_address == uart_lin_pkg::ADDR_CTRL ? ctrl_rd :
    avs_address == uart_lin_pkg::ADDR_ERR ? {5'h00, err_q} :
    avs_address == uart_lin_pkg::ADDR_RXBUF ? rx_buf_q :
    avs_address == uart_lin_pkg::ADDR_CLKSEL ? {4'h0, clk_sel_q} :
    avs_address == uart_lin_pkg::ADDR_DIV ? div_q :
    avs_address == uart_lin_pkg::ADDR_STAT ? stat_rd : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        avs_readdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  wire [11:0] sel_one = 12'h001 << clk_sel_q;
  wire [10:0] presc_mask = 11'(sel_one - 12'h001);
  wire base_tick = power && ((presc_q & presc_mask) == presc_mask);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= 11'h000;
    end else begin
      presc_q <= power ? presc_q + 11'h001 : 11'h000;
    end
  end

  // Pin synchroniser, then match filter on base ticks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_samp_q <= 1'b1;
      rx_filt_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_in_pin;
      rx_sync_q <= rx_meta_q;
      if (base_tick) begin
        rx_samp_q <= rx_sync_q;
        rx_prev_q <= rx_filt_q;
        if (rx_samp_q == rx_sync_q) begin
          rx_filt_q <= rx_sync_q;
        end
      end
    end
  end

  wire rx_wrap = base_tick && rx_cnt_q == div_q - 8'h01;
  wire tx_wrap = base_tick && tx_cnt_q == div_q - 8'h01;
  wire rx_sample = rx_wrap & ~rx_half_q;
  wire tx_bit_end = tx_wrap & tx_half_q;
  wire rx_idle = rx_state_q == uart_lin_pkg::RX_IDLE;
  wire rx_fall = base_tick & rx_prev_q & ~rx_filt_q;

  wire rx_stop_evt = rx_sample && rx_state_q == uart_lin_pkg::RX_STOP;
  wire par_bad = (par_mode == uart_lin_pkg::PAR_ODD & ~rx_par_q) |
                 (par_mode == uart_lin_pkg::PAR_EVEN & rx_par_q);
  wire [2:0] rx_errs = {~rx_filt_q, par_bad, rx_full_q};
  wire rx_any_err = |rx_errs;
  wire [7:0] rx_data = len8 ? rx_shift_q : {1'b0, rx_shift_q[7:1]};
  wire brk_evt = rx_sample && rx_state_q == uart_lin_pkg::RX_BRK && rx_filt_q;
  wire brk_ok = brk_evt && rx_low_q >= uart_lin_pkg::BRK_RX_MIN;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt_q <= 8'h00;
      rx_half_q <= 1'b0;
    end else if (!rx_run || rx_idle) begin
      rx_cnt_q <= 8'h00;
      rx_half_q <= 1'b0;
    end else if (base_tick) begin
      rx_cnt_q <= rx_wrap ? 8'h00 : rx_cnt_q + 8'h01;
      rx_half_q <= rx_half_q ^ rx_wrap;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q <= uart_lin_pkg::RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_bitn_q <= 3'h0;
      rx_par_q <= 1'b0;
      rx_low_q <= 5'h00;
    end else if (!rx_run) begin
      rx_state_q <= uart_lin_pkg::RX_IDLE;
    end else begin
      unique case (rx_state_q)
        uart_lin_pkg::RX_IDLE: begin
          if (rx_fall) begin
            rx_state_q <= uart_lin_pkg::RX_START;
          end
        end
        uart_lin_pkg::RX_START: begin
          if (rx_sample) begin
            rx_bitn_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_low_q <= 5'h01;
            if (rx_filt_q) begin
              rx_state_q <= uart_lin_pkg::RX_IDLE;
            end else begin
              rx_state_q <= brx_trig_q ? uart_lin_pkg::RX_BRK : uart_lin_pkg::RX_DATA;
            end
          end
        end
        uart_lin_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_shift_q <= {rx_filt_q, rx_shift_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_filt_q;
            rx_bitn_q <= rx_bitn_q + 3'h1;
            if (rx_bitn_q == last_bit) begin
              rx_state_q <= par_mode == uart_lin_pkg::PAR_NONE ?
                            uart_lin_pkg::RX_STOP : uart_lin_pkg::RX_PAR;
            end
          end
        end
        uart_lin_pkg::RX_PAR: begin
          if (rx_sample) begin
            rx_par_q <= rx_par_q ^ rx_filt_q;
            rx_state_q <= uart_lin_pkg::RX_STOP;
          end
        end
        uart_lin_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state_q <= uart_lin_pkg::RX_IDLE;
          end
        end
        uart_lin_pkg::RX_BRK: begin
          if (rx_sample) begin
            if (rx_filt_q) begin
              rx_state_q <= uart_lin_pkg::RX_IDLE;
            end else if (rx_low_q != 5'h1F) begin
              rx_low_q <= rx_low_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Transmit side
  wire tx_idle = tx_state_q == uart_lin_pkg::TX_IDLE;
  wire tx_frame_end = tx_state_q == uart_lin_pkg::TX_STOP && tx_bit_end && !tx_stop2_q;
  wire [5:0] blen_idx = 6'({3'h0, blen_sel_q} * 6'h05);
  wire [4:0] brk_len = BREAK_LEN_MAP[blen_idx +: 5];
  wire tx_brk_end = tx_state_q == uart_lin_pkg::TX_BRK && tx_bit_end &&
                    tx_brk_cnt_q == brk_len - 5'h01;
  wire tx_load = tx_run & tx_pend_q & (tx_idle | tx_frame_end);
  wire tx_brk_go = tx_run & tx_idle & btx_trig_q & ~tx_pend_q;
  wire par_bit = par_mode == uart_lin_pkg::PAR_ODD ? ~tx_par_q :
                 par_mode == uart_lin_pkg::PAR_EVEN ? tx_par_q : 1'b0;
  wire tx_line =
    tx_state_q == uart_lin_pkg::TX_DATA ? tx_shift_q[0] :
    tx_state_q == uart_lin_pkg::TX_PAR ? par_bit :
    (tx_state_q == uart_lin_pkg::TX_START || tx_state_q == uart_lin_pkg::TX_BRK) ? 1'b0 : 1'b1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_cnt_q <= 8'h00;
      tx_half_q <= 1'b0;
    end else if (!tx_run || tx_load || tx_brk_go) begin
      tx_cnt_q <= 8'h00;
      tx_half_q <= 1'b0;
    end else if (base_tick) begin
      tx_cnt_q <= tx_wrap ? 8'h00 : tx_cnt_q + 8'h01;
      tx_half_q <= tx_half_q ^ tx_wrap;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q <= uart_lin_pkg::TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_bitn_q <= 3'h0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      tx_brk_cnt_q <= 5'h00;
    end else if (!tx_run) begin
      tx_state_q <= uart_lin_pkg::TX_IDLE;
    end else if (tx_load) begin
      tx_state_q <= uart_lin_pkg::TX_START;
      tx_shift_q <= tx_buf_q;
    end else begin
      unique case (tx_state_q)
        uart_lin_pkg::TX_IDLE: begin
          if (tx_brk_go) begin
            tx_brk_cnt_q <= 5'h00;
            tx_state_q <= uart_lin_pkg::TX_BRK;
          end
        end
        uart_lin_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_bitn_q <= 3'h0;
            tx_par_q <= 1'b0;
            tx_state_q <= uart_lin_pkg::TX_DATA;
          end
        end
        uart_lin_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[7:1]};
            tx_par_q <= tx_par_q ^ tx_shift_q[0];
            tx_bitn_q <= tx_bitn_q + 3'h1;
            tx_stop2_q <= mode_q[uart_lin_pkg::MODE_STOP2];
            if (tx_bitn_q == last_bit) begin
              tx_state_q <= par_mode == uart_lin_pkg::PAR_NONE ?
                            uart_lin_pkg::TX_STOP : uart_lin_pkg::TX_PAR;
            end
          end
        end
        uart_lin_pkg::TX_PAR: begin
          if (tx_bit_end) begin
            tx_state_q <= uart_lin_pkg::TX_STOP;
          end
        end
        uart_lin_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_stop2_q <= 1'b0;
            if (!tx_stop2_q) begin
              tx_state_q <= uart_lin_pkg::TX_IDLE;
            end
          end
        end
        uart_lin_pkg::TX_BRK: begin
          if (tx_bit_end) begin
            tx_brk_cnt_q <= tx_brk_cnt_q + 5'h01;
            if (tx_brk_end) begin
              tx_state_q <= uart_lin_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Registers, flags and interrupt pulses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= uart_lin_pkg::MODE_RST;
      blen_sel_q <= 3'h0;
      btx_trig_q <= 1'b0;
      brx_trig_q <= 1'b0;
      brx_flag_q <= 1'b0;
      err_q <= 3'h0;
      rx_buf_q <= uart_lin_pkg::RXBUF_RST;
      rx_full_q <= 1'b0;
      tx_buf_q <= 8'h00;
      tx_pend_q <= 1'b0;
      clk_sel_q <= uart_lin_pkg::CLKSEL_RST;
      div_q <= uart_lin_pkg::DIV_RST;
      serial_out_pin <= 1'b1;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_done_irq <= 1'b0;
    end else begin
      if (wr_mode) mode_q <= wd;
      if (wr_clksel) clk_sel_q <= wd[3:0];
      if (wr_div) div_q <= wd;
      if (wr_txbuf) tx_buf_q <= wd;
      tx_pend_q <= tx_run & ((tx_pend_q & ~tx_load) | wr_txbuf);
      if (wr_ctrl) blen_sel_q <= wd[uart_lin_pkg::CTRL_BLEN_LO +: 3];
      btx_trig_q <= wr_ctrl ? wd[uart_lin_pkg::CTRL_BTX_TRIG] : btx_trig_q & ~tx_brk_end;
      brx_trig_q <= wr_ctrl ? wd[uart_lin_pkg::CTRL_BRX_TRIG] : brx_trig_q & ~brk_ok;
      // Clear wins: the state still shows break on the ending edge
      brx_flag_q <= (brx_flag_q | (rx_state_q == uart_lin_pkg::RX_BRK)) & ~brk_ok;
      err_q <= (rd_err ? 3'h0 : err_q) | (rx_stop_evt ? rx_errs : 3'h0);
      if (rx_stop_evt && !rx_full_q) rx_buf_q <= rx_data;
      rx_full_q <= (rx_full_q & ~rd_rxbuf) | rx_stop_evt;
      serial_out_pin <= tx_line;
      rx_done_irq <= (rx_stop_evt & (~rx_any_err | merge)) | brk_ok;
      rx_error_irq <= rx_stop_evt & rx_any_err & ~merge;
      tx_done_irq <= tx_frame_end | tx_brk_end;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_err_read_clear: assert property (rd_err && !rx_stop_evt |=> err_q == 3'h0)
    else $error("error status not cleared by read");
  a_err_irq_split: assert property (rx_stop_evt && rx_any_err && !merge |=>
    rx_error_irq && !rx_done_irq)
    else $error("error interrupt not separated");
  a_filter_agree: assert property (base_tick && rx_samp_q != rx_sync_q |=>
    $stable(rx_filt_q))
    else $error("filter moved on disagreeing samples");
  a_idle_line_high: assert property (tx_idle |=> serial_out_pin)
    else $error("idle output not high");
  a_brk_end_seq: assert property (tx_brk_end && !wr_ctrl |=>
    tx_done_irq && !serial_out_pin && !btx_trig_q ##1 serial_out_pin)
    else $error("break end sequence wrong");
  a_brk_long_done: assert property (brk_ok && !wr_ctrl |=>
    rx_done_irq && !brx_trig_q && !brx_flag_q && !rx_error_irq)
    else $error("long break not completed");
  a_brk_no_err: assert property (rx_state_q == uart_lin_pkg::RX_BRK |=>
    (err_q & ~$past(err_q)) == 3'h0 && $stable(rx_buf_q))
    else $error("break reception changed status or buffer");
  a_brk_short_armed: assert property (brk_evt && rx_low_q < uart_lin_pkg::BRK_RX_MIN
    && !wr_ctrl |=> brx_trig_q && brx_flag_q && !rx_done_irq)
    else $error("short break not ignored");
  a_cnt_held: assert property (!tx_run |=> tx_cnt_q == 8'h00 ##1 tx_cnt_q == 8'h00
    || tx_run)
    else $error("transmit counter ran while disabled");
  a_ovr_keeps_buf: assert property (rx_stop_evt && rx_full_q |=>
    $stable(rx_buf_q) && err_q[uart_lin_pkg::ERR_OVR])
    else $error("overrun overwrote buffer");

  c_brk_rx: cover property (brk_ok);
  c_brk_tx: cover property (tx_brk_end);
  c_rx_err: cover property (rx_stop_evt && rx_any_err);
endmodule : uart_lin_break_baud_gen

// ### common/uart_lin_pkg.sv
/*
  Register map, field positions, reset values and state types of the
  serial receiver/transmitter with break support and baud generator.
  Assumes a 32-bit Avalon-MM slave with word addresses 0 to 7.
*/
package uart_lin_pkg;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_ERR = 3'h2;
  localparam logic [2:0] ADDR_RXBUF = 3'h3;
  localparam logic [2:0] ADDR_TXBUF = 3'h4;
  localparam logic [2:0] ADDR_CLKSEL = 3'h5;
  localparam logic [2:0] ADDR_DIV = 3'h6;
  localparam logic [2:0] ADDR_STAT = 3'h7;
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_LEN8 = 2;
  localparam int MODE_STOP2 = 1;
  localparam int MODE_MERGE = 0;
  localparam int CTRL_BRX_FLAG = 7;
  localparam int CTRL_BRX_TRIG = 6;
  localparam int CTRL_BTX_TRIG = 5;
  localparam int CTRL_BLEN_LO = 2;
  localparam int ERR_OVR = 0;
  localparam int ERR_PAR = 1;
  localparam int ERR_FRM = 2;
  localparam int STAT_TX_PEND = 0;
  localparam int STAT_TX_BUSY = 1;
  localparam int STAT_RX_FULL = 2;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] RXBUF_RST = 8'hFF;
  localparam logic [7:0] DIV_RST = 8'hFF;
  localparam logic [3:0] CLKSEL_RST = 4'h0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [4:0] BRK_RX_MIN = 5'h0B;
  localparam logic [39:0] BRK_MAP_RST =
    {5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D};
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} rx_state_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} tx_state_e;
endpackage : uart_lin_pkg

// ### tb/uart_remote_node.sv
/*
  Remote serial node: drives frames and breaks onto serial_in_pin.
  Assumes a fixed bit time of BIT_CLKS clk_sys cycles and an idle-high line.
*/
`timescale 1ns/100ps
module uart_remote_node #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_sys,
  output logic serial_in_pin
);
  initial serial_in_pin = 1'b1;

  // Line rests high between frames
  task automatic idle();
    serial_in_pin <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_sys);
  endtask : idle

  task automatic send_bits(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    idle();
  endtask : send_bits

  task automatic send_low(input int bits);
    serial_in_pin <= 1'b0;
    repeat (bits * BIT_CLKS) @(posedge clk_sys);
    idle();
  endtask : send_low
endmodule : uart_remote_node

// ### tb/tb.sv
/*
  Testbench: register accesses over Avalon-MM, break send and receive,
  receive errors. Assumes divisor 8 and base clock equal to clk_sys.
*/
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic serial_in_pin;
  logic serial_out_pin;
  logic rx_done_irq;
  logic rx_error_irq;
  logic tx_done_irq;
  logic [31:0] rd;
  int fails = 0;
  int tests_run = 0;
  int n_done = 0;
  int n_err = 0;
  int n_tx = 0;
  int run_len = 0;
  int low_len = 0;
  int b;
  logic [2:0] ra [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  logic [31:0] rv [6] = '{32'h01, 32'h00, 32'h00, 32'hFF, 32'h00, 32'hFF};

  always #5 clk_sys = ~clk_sys;

  uart_lin_break_baud_gen dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .rx_done_irq(rx_done_irq),
    .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq)
  );

  uart_remote_node #(.BIT_CLKS(16)) peer (.clk_sys(clk_sys), .serial_in_pin(serial_in_pin));

  // Interrupt pulse counts and length of the last low stretch on the output
  always @(posedge clk_sys) begin
    n_done <= n_done + int'(rx_done_irq === 1'b1);
    n_err <= n_err + int'(rx_error_irq === 1'b1);
    n_tx <= n_tx + int'(tx_done_irq === 1'b1);
    if (serial_out_pin === 1'b0) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) low_len <= run_len;
      run_len <= 0;
    end
  end

  task automatic stop_test();
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      fails++;
      stop_test();
    end
  endtask : bus

  task automatic wait_tx(input int base);
    int i;
    for (i = 0; i < 1000 && n_tx == base; i++) @(posedge clk_sys);
    if (n_tx == base) begin
      fails++;
      stop_test();
    end
  endtask : wait_tx

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdc(input logic [2:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask : rdc

  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
    wr(uart_lin_pkg::ADDR_MODE, 32'h84);
    repeat (4) @(posedge clk_sys);
    check(serial_out_pin, 1'b1);
    wr(uart_lin_pkg::ADDR_MODE, 32'hE4);
    wr(uart_lin_pkg::ADDR_DIV, 32'h08);
    bus(1'b1, uart_lin_pkg::ADDR_DIV, 32'h20, 4'h0);
    rdc(uart_lin_pkg::ADDR_DIV, 32'h08);
    for (int c = 0; c < 8; c += 7) begin
      b = n_tx;
      wr(uart_lin_pkg::ADDR_CTRL, 32'h20 | (c << 2));
      wait_tx(b);
      repeat (4) @(posedge clk_sys);
      check(low_len, (13 + c) * 16);
      rdc(uart_lin_pkg::ADDR_CTRL, c << 2);
      repeat (200) @(posedge clk_sys);
      check(serial_out_pin, 1'b1);
      check(n_tx, b + 1);
    end
    b = n_tx;
    wr(uart_lin_pkg::ADDR_TXBUF, 32'h0F);
    wait_tx(b);
    repeat (4) @(posedge clk_sys);
    check(low_len, 64);
    check(n_tx, b + 1);
    rdc(uart_lin_pkg::ADDR_STAT, 32'h0);
    peer.send_bits({1'b1, 8'h5A, 1'b0}, 10);
    check(n_done, 1);
    check(n_err, 0);
    rdc(uart_lin_pkg::ADDR_ERR, 32'h0);
    rdc(uart_lin_pkg::ADDR_RXBUF, 32'h5A);
    peer.send_bits({1'b1, 8'h11, 1'b0}, 10);
    peer.send_bits({1'b1, 8'h22, 1'b0}, 10);
    check(n_err, 1);
    rdc(uart_lin_pkg::ADDR_ERR, 32'h1);
    rdc(uart_lin_pkg::ADDR_ERR, 32'h0);
    rdc(uart_lin_pkg::ADDR_RXBUF, 32'h11);
    b = n_done;
    wr(uart_lin_pkg::ADDR_CTRL, 32'h40);
    peer.send_low(13);
    check(n_done, b + 1);
    rdc(uart_lin_pkg::ADDR_CTRL, 32'h0);
    rdc(uart_lin_pkg::ADDR_ERR, 32'h0);
    rdc(uart_lin_pkg::ADDR_RXBUF, 32'h11);
    wr(uart_lin_pkg::ADDR_CTRL, 32'h40);
    peer.send_low(8);
    check(n_done, b + 1);
    bus(1'b0, uart_lin_pkg::ADDR_CTRL, 32'h0, 4'hF);
    check(rd & 32'hC0, 32'hC0);
    wr(uart_lin_pkg::ADDR_CTRL, 32'h0);
    peer.send_bits({1'b0, 8'h33, 1'b0}, 10);
    check(n_err, 2);
    rdc(uart_lin_pkg::ADDR_ERR, 32'h4);
    bus(1'b0, uart_lin_pkg::ADDR_RXBUF, 32'h0, 4'hF);
    wr(uart_lin_pkg::ADDR_MODE, 32'hFC);
    for (int p = 0; p < 2; p++) begin
      peer.send_bits({1'b1, p[0], 8'h5A, 1'b0}, 11);
      rdc(uart_lin_pkg::ADDR_ERR, p ? 32'h2 : 32'h0);
      bus(1'b0, uart_lin_pkg::ADDR_RXBUF, 32'h0, 4'hF);
    end
    wr(uart_lin_pkg::ADDR_MODE, 32'hE5);
    b = n_done;
    peer.send_bits({1'b0, 8'h44, 1'b0}, 10);
    check(n_done, b + 1);
    check(n_err, 3);
    stop_test();
  end
endmodule : tb
